// [design/tmr_defines.vh]
`ifndef TMR_DEFINES_VH
`define TMR_DEFINES_VH

// register byte offsets
`define TMR_OFS_CTRL 8'h00
`define TMR_OFS_PRESC 8'h04
`define TMR_OFS_COUNT 8'h08
`define TMR_OFS_CMPA 8'h0c
`define TMR_OFS_CMPB 8'h10
`define TMR_OFS_CAPT 8'h14
`define TMR_OFS_FLAGS 8'h18
`define TMR_OFS_FORCE 8'h1c
`define TMR_OFS_PORT 8'h20

// control register fields
`define TMR_CTRL_MODE_LSB 0
`define TMR_CTRL_MODE_MSB 3
`define TMR_CTRL_ACT_LSB 4
`define TMR_CTRL_ACT_MSB 7
`define TMR_CTRL_RUN_BIT 8

// flag register bits
`define TMR_FLAG_OVF 0
`define TMR_FLAG_CMPA 1
`define TMR_FLAG_CMPB 2
`define TMR_FLAG_CAPT 3

// port register fields
`define TMR_PORT_VAL_LSB 0
`define TMR_PORT_DIR_LSB 2

// waveform modes handled here
`define TMR_MODE_NORMAL 4'h0
`define TMR_MODE_CTC_CMPA 4'h4
`define TMR_MODE_CTC_CAPT 4'hc

// output action codes for non-pwm modes
`define TMR_ACT_NONE 2'h0
`define TMR_ACT_TOGGLE 2'h1
`define TMR_ACT_CLEAR 2'h2
`define TMR_ACT_SET 2'h3

// counter extremes and reset values
`define TMR_CNT_MAX 16'hffff
`define TMR_CNT_BOTTOM 16'h0000
`define TMR_PRESC_RST 16'h0000

// bus responses
`define TMR_RESP_OKAY 2'h0
`define TMR_RESP_SLVERR 2'h2

`endif

// [design/tmr_cmp_out.v]
`include "tmr_defines.vh"
`timescale 1ns/1ps
`default_nettype none

// one compare output channel: state flop plus port pin override
module tmr_cmp_out (
    input wire aclk,
    input wire aresetn,
    input wire match_evt,
    input wire force_evt,
    input wire [1:0] action,
    input wire port_val,
    input wire pin_dir,
    output reg state_ff,
    output reg pin_out_ff,
    output reg pin_oe_n_ff
);

    reg nxt_state; // state after this cycle's event

    ////////////////////////////////////////////////////////////////////////
    // action applied on a real or forced match, action read live
    always @* begin
        nxt_state = state_ff;
        if (match_evt || force_evt) begin
            case (action)
                `TMR_ACT_TOGGLE: nxt_state = ~state_ff;
                `TMR_ACT_CLEAR: nxt_state = 1'b0;
                `TMR_ACT_SET: nxt_state = 1'b1;
                default: nxt_state = state_ff;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state clears only on reset, a clear action or a toggle of a set state, never on a mode change
    always @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= 1'b0;
            pin_out_ff <= 1'b0;
            pin_oe_n_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            // any nonzero action hands the pin to the compare state
            pin_out_ff <= (action != `TMR_ACT_NONE) ? nxt_state
                                                    : port_val;
            // direction stays with the port bit, low enable drives
            pin_oe_n_ff <= ~pin_dir;
        end
    end

endmodule // tmr_cmp_out

`default_nettype wire

// [design/tmr_top.v]
`include "tmr_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module tmr_top #(
    parameter ADDR_W = 8
) (
    input wire aclk,
    input wire aresetn,
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire overflow_ack,
    input wire compare_a_ack,
    input wire compare_b_ack,
    input wire capture_ack,
    output wire [3:0] flags_out,
    output wire [1:0] compare_pin_out,
    output wire [1:0] compare_pin_oe_n
);

    ////////////////////////////////////////////////////////////////////////
    // state
    reg [3:0] mode_ff; // waveform_mode_select
    reg [3:0] act_ff; // output_action_select b:a
    reg run_ff; // timer clock enabled
    reg [15:0] presc_ff; // tick every presc+1 system clocks
    reg [15:0] div_ff; // prescaler down count
    reg tick_ff; // one-cycle timer clock enable
    reg [15:0] cnt_ff; // counter_value
    reg [15:0] cmpa_ff; // compare_value_a
    reg [15:0] cmpb_ff; // compare_value_b
    reg [15:0] capt_ff; // capture_value
    reg block_ff; // matches blocked until next tick
    reg [3:0] flags_ff; // sticky flags
    reg [1:0] port_val_ff; // general port output values
    reg [1:0] dir_ff; // pin_direction_bit b:a
    reg aw_full_ff; // write address held
    reg w_full_ff; // write data held
    reg [ADDR_W-1:0] awaddr_ff;
    reg [31:0] wdata_ff;
    reg [3:0] wstrb_ff;

    wire [1:0] state_w; // compare_output_state b:a

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // map an offset to a known register
    function addr_ok;
        input [ADDR_W-1:0] a;
        begin
            case (a)
                `TMR_OFS_CTRL, `TMR_OFS_PRESC, `TMR_OFS_COUNT,
                `TMR_OFS_CMPA, `TMR_OFS_CMPB, `TMR_OFS_CAPT,
                `TMR_OFS_FLAGS, `TMR_OFS_FORCE, `TMR_OFS_PORT: addr_ok = 1'b1;
                default: addr_ok = 1'b0;
            endcase
        end
    endfunction

    // read value of a register, unmapped reads zero
    function [31:0] rd_word;
        input [ADDR_W-1:0] a;
        begin
            case (a)
                `TMR_OFS_CTRL: rd_word = {23'h000000, run_ff, act_ff,
                                          mode_ff};
                `TMR_OFS_PRESC: rd_word = {16'h0000, presc_ff};
                `TMR_OFS_COUNT: rd_word = {16'h0000, cnt_ff};
                `TMR_OFS_CMPA: rd_word = {16'h0000, cmpa_ff};
                `TMR_OFS_CMPB: rd_word = {16'h0000, cmpb_ff};
                `TMR_OFS_CAPT: rd_word = {16'h0000, capt_ff};
                `TMR_OFS_FLAGS: rd_word = {28'h0000000, flags_ff};
                `TMR_OFS_FORCE: rd_word = {30'h00000000, state_w};
                `TMR_OFS_PORT: rd_word = {28'h0000000, dir_ff, port_val_ff};
                default: rd_word = 32'h00000000;
            endcase
        end
    endfunction

    // byte lane merge under write strobes
    function [31:0] merge;
        input [31:0] old;
        input [31:0] d;
        input [3:0] strb;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    merge[i*8 +: 8] = d[i*8 +: 8];
                end
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // write decode
    wire wr_go = aw_full_ff && w_full_ff && !s_axi_bvalid;
    wire [31:0] wr_word = merge(rd_word(awaddr_ff), wdata_ff, wstrb_ff);
    wire [31:0] wr_bits = merge(32'h00000000, wdata_ff, wstrb_ff);
    wire wr_ctrl = wr_go && (awaddr_ff == `TMR_OFS_CTRL);
    wire wr_cnt = wr_go && (awaddr_ff == `TMR_OFS_COUNT);
    wire wr_flags = wr_go && (awaddr_ff == `TMR_OFS_FLAGS);
    wire wr_force = wr_go && (awaddr_ff == `TMR_OFS_FORCE);

    ////////////////////////////////////////////////////////////////////////
    // match logic
    wire non_pwm = (mode_ff == `TMR_MODE_NORMAL) ||
                   (mode_ff == `TMR_MODE_CTC_CMPA) ||
                   (mode_ff == `TMR_MODE_CTC_CAPT);
    wire ctc_capt = (mode_ff == `TMR_MODE_CTC_CAPT);
    wire ctc = (mode_ff == `TMR_MODE_CTC_CMPA) || ctc_capt;
    // top register picked by mode only
    wire [15:0] top_val = ctc_capt ? capt_ff : cmpa_ff;
    // a live tick that is not shadowed by a counter write
    wire live = tick_ff && !block_ff;
    wire match_a = live && (cnt_ff == cmpa_ff);
    wire match_b = live && (cnt_ff == cmpb_ff);
    // equality only: a top below the count is passed by
    wire top_hit = live && ctc && (cnt_ff == top_val);
    wire [1:0] match_v = {match_b, match_a};
    // force is ignored in pwm modes and never touches flags
    wire [1:0] force_v = (wr_force && non_pwm) ? wr_bits[1:0]
                                               : 2'b00;

    ////////////////////////////////////////////////////////////////////////
    // prescaler: one-cycle tick enable, no second clock
    always @(posedge aclk) begin
        if (!aresetn) begin
            div_ff <= `TMR_PRESC_RST;
            tick_ff <= 1'b0;
        end else if (!run_ff) begin
            div_ff <= presc_ff;
            tick_ff <= 1'b0;
        end else if (div_ff == 16'h0000) begin
            div_ff <= presc_ff;
            tick_ff <= 1'b1;
        end else begin
            div_ff <= div_ff - 16'h0001;
            tick_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // counter and match blocking
    always @(posedge aclk) begin
        if (!aresetn) begin
            cnt_ff <= `TMR_CNT_BOTTOM;
            block_ff <= 1'b0;
        end else if (wr_cnt) begin
            // blocking holds even while stopped, until the next tick
            cnt_ff <= wr_word[15:0];
            block_ff <= 1'b1;
        end else if (tick_ff) begin
            block_ff <= 1'b0;
            if (top_hit) begin
                cnt_ff <= `TMR_CNT_BOTTOM;
            end else begin
                // normal mode never clears, wraps at max
                cnt_ff <= cnt_ff + 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // flags: hardware set wins over any clear in the same cycle
    reg [3:0] nxt_flags_set;
    reg [3:0] nxt_flags_clr;
    always @* begin
        nxt_flags_set = 4'h0;
        nxt_flags_clr = 4'h0;
        // wrap of max to zero, unless software overwrote the count
        nxt_flags_set[`TMR_FLAG_OVF] = tick_ff && !wr_cnt &&
            (top_hit || (cnt_ff == `TMR_CNT_MAX)) &&
            (cnt_ff == `TMR_CNT_MAX);
        nxt_flags_set[`TMR_FLAG_CMPA] = match_a;
        nxt_flags_set[`TMR_FLAG_CMPB] = match_b;
        nxt_flags_set[`TMR_FLAG_CAPT] = top_hit && ctc_capt;
        if (wr_flags) begin
            nxt_flags_clr = wr_bits[3:0];
        end
        nxt_flags_clr = nxt_flags_clr | {capture_ack, compare_b_ack,
                                         compare_a_ack,
                                         overflow_ack};
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            flags_ff <= 4'h0;
        end else begin
            flags_ff <= (flags_ff & ~nxt_flags_clr) | nxt_flags_set;
        end
    end

    assign flags_out = flags_ff;

    ////////////////////////////////////////////////////////////////////////
    // software registers
    always @(posedge aclk) begin
        if (!aresetn) begin
            mode_ff <= `TMR_MODE_NORMAL;
            act_ff <= 4'h0;
            run_ff <= 1'b0;
            presc_ff <= `TMR_PRESC_RST;
            cmpa_ff <= 16'h0000;
            cmpb_ff <= 16'h0000;
            capt_ff <= 16'h0000;
            port_val_ff <= 2'b00;
            dir_ff <= 2'b00;
        end else if (wr_go) begin
            case (awaddr_ff)
                `TMR_OFS_CTRL: begin
                    // mode change leaves output state alone
                    mode_ff <= wr_word[`TMR_CTRL_MODE_MSB:
                                       `TMR_CTRL_MODE_LSB];
                    act_ff <= wr_word[`TMR_CTRL_ACT_MSB:
                                      `TMR_CTRL_ACT_LSB];
                    run_ff <= wr_word[`TMR_CTRL_RUN_BIT];
                end
                `TMR_OFS_PRESC: presc_ff <= wr_word[15:0];
                // straight into the live compare value, no buffer
                `TMR_OFS_CMPA: cmpa_ff <= wr_word[15:0];
                `TMR_OFS_CMPB: cmpb_ff <= wr_word[15:0];
                `TMR_OFS_CAPT: capt_ff <= wr_word[15:0];
                `TMR_OFS_PORT: begin
                    port_val_ff <= wr_word[`TMR_PORT_VAL_LSB +: 2];
                    dir_ff <= wr_word[`TMR_PORT_DIR_LSB +: 2];
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // compare output channels a and b; capture path never sees act_ff
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_ch
            tmr_cmp_out u_out (
                .aclk(aclk),
                .aresetn(aresetn),
                .match_evt(match_v[gi]),
                .force_evt(force_v[gi]),
                .action(act_ff[gi*2 +: 2]),
                .port_val(port_val_ff[gi]),
                .pin_dir(dir_ff[gi]),
                .state_ff(state_w[gi]),
                .pin_out_ff(compare_pin_out[gi]),
                .pin_oe_n_ff(compare_pin_oe_n[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // axi write channels: address and data taken in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_ff <= 1'b0;
            w_full_ff <= 1'b0;
            awaddr_ff <= {ADDR_W{1'b0}};
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `TMR_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            // the write lands here, response raised on the same edge
            if (wr_go) begin
                aw_full_ff <= 1'b0;
                w_full_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= addr_ok(awaddr_ff) ? `TMR_RESP_OKAY
                                                  : `TMR_RESP_SLVERR;
            end
            // ready again only once the response is taken
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // axi read channel, one read under way at a time
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `TMR_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word(s_axi_araddr);
            s_axi_rresp <= addr_ok(s_axi_araddr) ? `TMR_RESP_OKAY
                                                 : `TMR_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule // tmr_top

`default_nettype wire

// [testbench/tmr_chk_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////
// watches bus handshakes, flags and pin enables at the top ports
module tmr_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic overflow_ack,
    input wire logic compare_a_ack,
    input wire logic [3:0] flags_out,
    input wire logic [1:0] compare_pin_out,
    input wire logic [1:0] compare_pin_oe_n
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////
    // outputs come out of reset cleared, pins released
    a_reset_idle: assert property (
        $rose(aresetn) |-> flags_out == 4'h0 && compare_pin_out == 2'h0
            && compare_pin_oe_n == 2'h3)
        else $error("outputs not idle after reset");
    // write answer holds until taken
    a_bvalid_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped early");
    // read answer one edge after the address is taken
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    a_rvalid_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("rvalid dropped early");
    // no new write address while a response waits
    a_aw_blocked: assert property (
        s_axi_bvalid |-> !s_axi_awready)
        else $error("awready high during response");
    // acknowledge clears the flag; allows one output stage of slack
    a_ovf_ack_clear: assert property (
        overflow_ack |-> ##[1:2] !flags_out[0])
        else $error("overflow flag not cleared by ack");
    a_cmpa_ack_clear: assert property (
        compare_a_ack |-> ##[1:2] !flags_out[1])
        else $error("compare a flag not cleared by ack");
    // counting alone never clears overflow; only ack or a write may
    a_ovf_sticky: assert property (
        flags_out[0] && !overflow_ack && !$past(overflow_ack)
            && !s_axi_bvalid |=> flags_out[0] || s_axi_bvalid)
        else $error("overflow flag cleared by counting");
    // pin direction moves only with a register write
    a_oe_by_write: assert property (
        $changed(compare_pin_oe_n) |-> s_axi_bvalid || $past(s_axi_bvalid))
        else $error("pin enable changed without write");
    c_ovf_ack: cover property (overflow_ack && flags_out[0]);
    c_pin_move: cover property ($changed(compare_pin_out));
    c_capt_flag: cover property ($rose(flags_out[3]));
endmodule // tmr_chk
`default_nettype wire

// [testbench/tmr_pin_model.sv]
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////
// board side of the compare pins: port pull-up holds undriven pins high
module tmr_pin_model (
    input wire logic [1:0] compare_pin_out,
    input wire logic [1:0] compare_pin_oe_n,
    output logic [1:0] pin_level
);
    // a released pin reads high whatever value was last driven
    assign pin_level = (compare_pin_out & ~compare_pin_oe_n)
        | compare_pin_oe_n;
endmodule // tmr_pin_model
`default_nettype wire

// [testbench/test_timer16_compare_output_normal_ctc.sv]
`include "tmr_defines.vh"
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////
module test_timer16_compare_output_normal_ctc;
    typedef struct packed {
        logic [3:0] mode;
        logic [1:0] act;
        logic st;
    } tmr_row_t;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic ovf_ack = 1'b0;
    logic cmpa_ack = 1'b0;
    logic capt_ack = 1'b0;
    wire awready, wready, bvalid, arready, rvalid;
    wire [1:0] bresp, rresp, pin_out, pin_oe_n, pin_level;
    wire [31:0] rdata;
    wire [3:0] flags;
    int error_cnt = 0;
    int compares = 0;
    int cycles = 0;
    int n;
    int c;
    logic [31:0] rd;
    logic [31:0] prev;
    logic [1:0] rsp;
    // force through every action code, then keep state across modes
    tmr_row_t rows [6] = '{'{4'h0, 2'h3, 1'b1}, '{4'h0, 2'h0, 1'b1},
        '{4'h0, 2'h2, 1'b0}, '{4'h0, 2'h1, 1'b1},
        '{4'h4, 2'h1, 1'b0}, '{4'hc, 2'h3, 1'b1}};
    tmr_top tmr_top_i (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .overflow_ack(ovf_ack),
        .compare_a_ack(cmpa_ack), .compare_b_ack(1'b0),
        .capture_ack(capt_ack), .flags_out(flags),
        .compare_pin_out(pin_out), .compare_pin_oe_n(pin_oe_n));
    tmr_pin_model tmr_pin_model_i (.compare_pin_out(pin_out),
        .compare_pin_oe_n(pin_oe_n), .pin_level(pin_level));
    ////////////////////////////////////////////////////////////////////////
    always #5 aclk = ~aclk;
    // whole run needs a few hundred cycles; ceiling well above
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt = error_cnt + 1;
            test_done;
        end
    end
    task test_done;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one write: address and data offered together, each dropped when taken
    task axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            n++;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        rsp = bresp;
    endtask
    task axr(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
            n++;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        rd = rdata;
        rsp = rresp;
    endtask
    // cycles until pin a changes level
    task wpin;
        logic v;
        v = pin_level[0];
        c = 0;
        do begin
            @(posedge aclk);
            c++;
        end while (pin_level[0] === v && c < 100);
    endtask
    // one-cycle acknowledge pulse, then let the clear land
    task pulse(input int k);
        @(posedge aclk);
        ovf_ack <= (k == 0);
        cmpa_ack <= (k == 1);
        capt_ack <= (k == 3);
        @(posedge aclk);
        {ovf_ack, cmpa_ack, capt_ack} <= 3'h0;
        repeat (2) @(posedge aclk);
        chk("flag_after_ack", 32'h0, flags[k]);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk("flags", 32'h0, flags);
        chk("oe_n", 32'h3, pin_oe_n);
        axr(`TMR_OFS_FORCE);
        chk("state", 32'h0, rd);
        axr(8'h24);
        chk("rresp", `TMR_RESP_SLVERR, rsp);
        axw(8'h24, 32'h1);
        chk("bresp", `TMR_RESP_SLVERR, rsp);
        // state fixed by a forced clear in normal mode before the pin drives
        axw(`TMR_OFS_CTRL, 32'h20);
        axw(`TMR_OFS_FORCE, 32'h1);
        // pin a output, port value 0
        axw(`TMR_OFS_PORT, 32'h4);
        for (int i = 0; i < 6; i++) begin
            axw(`TMR_OFS_CTRL, {26'h0, rows[i].act, rows[i].mode});
            axw(`TMR_OFS_FORCE, 32'h1);
            axr(`TMR_OFS_FORCE);
            chk("state", {31'h0, rows[i].st}, rd);
            chk("pin", {31'h0, (rows[i].act != 2'h0) & rows[i].st},
                pin_level[0]);
            chk("pin_b", 32'h1, pin_level[1]);
            chk("flags", 32'h0, flags);
        end
        // toggle on every top match, top from compare a
        axw(`TMR_OFS_CMPA, 32'h3);
        axw(`TMR_OFS_COUNT, 32'h0);
        axw(`TMR_OFS_CTRL, 32'h114);
        wpin;
        wpin;
        chk("half_period", 32'h4, c);
        chk("cmpa_flag", 32'h1, flags[1]);
        axw(`TMR_OFS_CTRL, 32'h14);
        axr(`TMR_OFS_COUNT);
        chk("count_le_top", 32'h1, rd <= 32'h3);
        pulse(1);
        // count written equal to top: blocked match, runs past top
        axw(`TMR_OFS_FLAGS, 32'hf);
        axw(`TMR_OFS_CMPA, 32'h5);
        axw(`TMR_OFS_COUNT, 32'h5);
        axw(`TMR_OFS_CTRL, 32'h114);
        repeat (8) @(posedge aclk);
        axw(`TMR_OFS_CTRL, 32'h14);
        axr(`TMR_OFS_COUNT);
        prev = rd;
        chk("past_top", 32'h1, rd > 32'h5);
        chk("cmpa_flag", 32'h0, flags[1]);
        // new top below count takes effect at once and is missed
        axw(`TMR_OFS_CMPA, 32'h2);
        axw(`TMR_OFS_CTRL, 32'h114);
        repeat (8) @(posedge aclk);
        axw(`TMR_OFS_CTRL, 32'h14);
        axr(`TMR_OFS_COUNT);
        chk("no_early_clear", 32'h1, rd > prev);
        // normal mode wrap and overflow
        axw(`TMR_OFS_COUNT, 32'hfffd);
        axw(`TMR_OFS_CTRL, 32'h100);
        n = 0;
        while (flags[0] !== 1'b1 && n < 30) begin
            @(posedge aclk);
            n++;
        end
        chk("ovf_flag", 32'h1, flags[0]);
        axw(`TMR_OFS_CTRL, 32'h0);
        axr(`TMR_OFS_COUNT);
        chk("wrapped", 32'h1, rd < 32'h20);
        pulse(0);
        // top from capture value
        axw(`TMR_OFS_CAPT, 32'h2);
        axw(`TMR_OFS_COUNT, 32'h0);
        axw(`TMR_OFS_CTRL, 32'h10c);
        n = 0;
        while (flags[3] !== 1'b1 && n < 30) begin
            @(posedge aclk);
            n++;
        end
        chk("capt_flag", 32'h1, flags[3]);
        axw(`TMR_OFS_CTRL, 32'hc);
        axr(`TMR_OFS_COUNT);
        chk("count_le_capt", 32'h1, rd <= 32'h2);
        pulse(3);
        // mid-run reset: a forced-high state must come back cleared
        axw(`TMR_OFS_CTRL, 32'h30);
        axw(`TMR_OFS_FORCE, 32'h1);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axr(`TMR_OFS_FORCE);
        chk("state_after_reset", 32'h0, rd);
        chk("oe_n_after_reset", 32'h3, pin_oe_n);
        test_done;
    end
endmodule // test_timer16_compare_output_normal_ctc
bind tmr_top tmr_chk tmr_chk_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .overflow_ack(overflow_ack),
    .compare_a_ack(compare_a_ack), .flags_out(flags_out),
    .compare_pin_out(compare_pin_out), .compare_pin_oe_n(compare_pin_oe_n));
`default_nettype wire
